//--- include/fes_pkg.sv
/*
 Shared constants and carrier types for the erase, suspend and resume sequencer.
 Assumes a single 25 MHz core clock; link signals arrive unsynchronised.
*/
package fes_pkg;
   // Opcodes
   localparam logic [7:0] OP_BLOCK_ERASE64 = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE32 = 8'h52;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   // Frame lengths in bits
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_OP_ADDR = 6'h20;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned BLOCK_SHIFT = 16;
   localparam int unsigned BP_W = 5;
   localparam int unsigned BLOCK_IDX_W = ADDR_W - BLOCK_SHIFT;
   // Clock and timing
   localparam int unsigned MCLK_HZ = 25_000_000;
   localparam int unsigned RESUME_WIP_NS = 200;
   // Longest time rounds down, but not below one cycle
   localparam int unsigned RESUME_WIP_CYC_RAW = RESUME_WIP_NS * (MCLK_HZ / 1_000_000) / 1000;
   localparam int unsigned RESUME_WIP_CYC = (RESUME_WIP_CYC_RAW < 1) ? 1 : RESUME_WIP_CYC_RAW;
   localparam logic [4:0] RESUME_WIP_DLY = 5'(RESUME_WIP_CYC - 1);
   // Self-timed durations in ms (page program in us) as printed defaults
   localparam int unsigned BLOCK_ERASE_MS = 250;
   localparam int unsigned CHIP_ERASE_MS = 25000;
   localparam int unsigned PAGE_PROG_US = 600;
   localparam int unsigned SECTOR_ERASE_MS = 50;
   localparam logic [31:0] CYC_PER_MS = 32'(MCLK_HZ / 1000);
   localparam logic [31:0] CYC_PER_US = 32'(MCLK_HZ / 1_000_000);

   typedef enum logic [2:0] {
      FES_OP_NONE, FES_OP_SECTOR, FES_OP_BLOCK, FES_OP_CHIP, FES_OP_PROGRAM
   } fes_op_t;

   // Status seen by the host on a status read
   typedef struct packed {
      logic paused;
      logic write_enable_latch;
      logic write_in_progress;
   } fes_status_t;

   // Decoded end-of-frame command
   typedef struct packed {
      logic [7:0] opcode;
      logic [ADDR_W-1:0] addr;
      logic [5:0] bits;
   } fes_frame_t;
endpackage : fes_pkg

//--- hdl/fes_sequencer.sv
/*
 Erase, suspend and resume command sequencer of a serial NOR flash.
 Assumes the link pins are asynchronous to mclk and much slower (sclk >= 4 mclk periods
 per half), and that write-enable and page-program framing live elsewhere.
*/
// Behaviour
// - Block erase is opcode plus three address bytes
// - Chip select rising off byte boundary discards
// - Block erase runs timed, in-progress flag high
// - Write latch cleared during block erase
// - Protected block is never erased
// - Two chip erase opcodes, memory goes ones
// - Chip erase needs write latch set
// - Chip erase needs exactly eight bits
// - Chip erase busy, then clears both flags
// - Chip erase only when unprotected
// - Suspend pauses sector, block erase, program
// - Suspend ignored during chip erase
// - Resume needs paused set, in-progress clear
// - Resume clears paused, busy within 200 ns
`timescale 1ns/1ps
module fes_sequencer
   import fes_pkg::*;
#(
   parameter int unsigned BLOCK_ERASE_CYC = BLOCK_ERASE_MS * CYC_PER_MS,
   parameter int unsigned CHIP_ERASE_CYC = CHIP_ERASE_MS * CYC_PER_MS,
   parameter int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CYC_PER_MS,
   parameter int unsigned PAGE_PROG_CYC = PAGE_PROG_US * CYC_PER_US
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic serial_in_line,
   input wire logic [BP_W-1:0] block_protect_bits,
   input wire logic set_write_enable,
   input wire logic start_sector_erase,
   input wire logic start_page_program,
   output fes_status_t status,
   output logic erase_block_pulse,
   output logic [BLOCK_IDX_W-1:0] erase_block_index,
   output logic erase_all_pulse
);
   // Two-flop synchronisers; stage one feeds only stage two
   logic [2:0] sync1_q, sync2_q, sync1_d, sync2_d;
   logic cs_prev_q, cs_prev_d, sck_prev_q, sck_prev_d;
   always_comb begin
      sync1_d = {chip_select_n, serial_clock, serial_in_line};
      sync2_d = sync1_q;
      cs_prev_d = sync2_q[2];
      sck_prev_d = sync2_q[1];
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         // Reset to the idle link levels so the clock edge detector sees no false rise
         sync1_q <= 3'h4;
         sync2_q <= 3'h4;
         cs_prev_q <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         cs_prev_q <= cs_prev_d;
         sck_prev_q <= sck_prev_d;
      end
   end
   logic cs_n, sck_rise, frame_end;
   assign cs_n = sync2_q[2];
   assign sck_rise = sync2_q[1] & ~sck_prev_q & ~cs_n;
   assign frame_end = cs_n & ~cs_prev_q;

   // Frame shifter: MSB first, counts bits, saturates past address
   fes_frame_t frame_q, frame_d;
   always_comb begin
      frame_d = frame_q;
      if (cs_prev_q && !cs_n) begin
         frame_d = '0;
      end else if (sck_rise) begin
         if (frame_q.bits < BITS_OPCODE) begin
            frame_d.opcode = {frame_q.opcode[6:0], sync2_q[0]};
         end else begin
            frame_d.addr = {frame_q.addr[ADDR_W-2:0], sync2_q[0]};
         end
         if (frame_q.bits != 6'h3f) begin
            frame_d.bits = frame_q.bits + 6'h01;
         end
      end
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         frame_q <= '0;
      end else begin
         frame_q <= frame_d;
      end
   end

   // Protected-block lookup: upper blocks protected, count set by protect bits
   function automatic logic block_protected(input logic [BLOCK_IDX_W-1:0] idx,
                                            input logic [BP_W-1:0] bp);
      logic [BLOCK_IDX_W:0] span;
      span = '0;
      if (bp != '0) begin
         // Any setting above eight, top bit included, covers the whole array
         span = (bp > 5'h08) ? 9'h100 : 9'((1 << bp[3:0]));
      end
      block_protected = ({1'b0, idx} >= (9'h100 - span));
   endfunction : block_protected

   // Operation engine
   fes_op_t op_q, op_d;
   logic wip_q, wip_d, wel_q, wel_d, sus_q, sus_d;
   logic [31:0] cnt_q, cnt_d;
   logic [4:0] rdly_q, rdly_d;
   logic rpend_q, rpend_d;
   logic ebp_d, eap_d;
   logic [BLOCK_IDX_W-1:0] ebi_q, ebi_d;
   logic ebp_q, eap_q;
   logic blk_cmd, chip_cmd;
   assign blk_cmd = frame_end && frame_q.opcode == OP_BLOCK_ERASE64
                    && frame_q.bits == BITS_OP_ADDR;
   assign chip_cmd = frame_end && frame_q.bits == BITS_OPCODE
                     && (frame_q.opcode == OP_CHIP_ERASE_A
                         || frame_q.opcode == OP_CHIP_ERASE_B);

   always_comb begin
      op_d = op_q;
      wip_d = wip_q;
      wel_d = wel_q;
      sus_d = sus_q;
      cnt_d = cnt_q;
      rdly_d = rdly_q;
      rpend_d = rpend_q;
      ebp_d = 1'b0;
      eap_d = 1'b0;
      ebi_d = ebi_q;
      if (set_write_enable && !wip_q) begin
         wel_d = 1'b1;
      end
      if (wip_q) begin
         // Latch dropped on first busy cycle except in chip erase, which keeps it until completion
         if (op_q != FES_OP_CHIP) begin
            wel_d = 1'b0;
         end
         if (cnt_q <= 32'h1) begin
            wip_d = 1'b0;
            wel_d = 1'b0;
            if (op_q == FES_OP_BLOCK) begin
               ebp_d = 1'b1;
            end
            if (op_q == FES_OP_CHIP) begin
               eap_d = 1'b1;
            end
            op_d = FES_OP_NONE;
         end else begin
            cnt_d = cnt_q - 32'h1;
         end
         if (frame_end && frame_q.bits == BITS_OPCODE && frame_q.opcode == OP_SUSPEND
             && op_q != FES_OP_CHIP) begin
            wip_d = 1'b0;
            sus_d = 1'b1;
            ebp_d = 1'b0;
            op_d = op_q;
            cnt_d = cnt_q;
         end
      end else if (rpend_q) begin
         // Busy rises a fixed count after an accepted resume
         if (rdly_q == 5'h00) begin
            rpend_d = 1'b0;
            wip_d = 1'b1;
         end else begin
            rdly_d = rdly_q - 5'h01;
         end
      end else if (sus_q) begin
         if (frame_end && frame_q.bits == BITS_OPCODE
             && frame_q.opcode == OP_RESUME) begin
            sus_d = 1'b0;
            rpend_d = 1'b1;
            rdly_d = RESUME_WIP_DLY;
         end
      end else begin
         // Idle: accept new self-timed work; a refused command changes nothing
         if (blk_cmd && wel_q
             && !block_protected(frame_q.addr[ADDR_W-1:BLOCK_SHIFT],
                                 block_protect_bits)) begin
            op_d = FES_OP_BLOCK;
            wip_d = 1'b1;
            cnt_d = 32'(BLOCK_ERASE_CYC);
            ebi_d = frame_q.addr[ADDR_W-1:BLOCK_SHIFT];
         end else if (chip_cmd && wel_q && block_protect_bits == '0) begin
            op_d = FES_OP_CHIP;
            wip_d = 1'b1;
            cnt_d = 32'(CHIP_ERASE_CYC);
         end else if (start_sector_erase && wel_q) begin
            op_d = FES_OP_SECTOR;
            wip_d = 1'b1;
            cnt_d = 32'(SECTOR_ERASE_CYC);
         end else if (start_page_program && wel_q) begin
            op_d = FES_OP_PROGRAM;
            wip_d = 1'b1;
            cnt_d = 32'(PAGE_PROG_CYC);
         end
      end
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         op_q <= FES_OP_NONE;
         wip_q <= 1'b0;
         wel_q <= 1'b0;
         sus_q <= 1'b0;
         cnt_q <= '0;
         rdly_q <= '0;
         rpend_q <= 1'b0;
         ebp_q <= 1'b0;
         eap_q <= 1'b0;
         ebi_q <= '0;
      end else begin
         op_q <= op_d;
         wip_q <= wip_d;
         wel_q <= wel_d;
         sus_q <= sus_d;
         cnt_q <= cnt_d;
         rdly_q <= rdly_d;
         rpend_q <= rpend_d;
         ebp_q <= ebp_d;
         eap_q <= eap_d;
         ebi_q <= ebi_d;
      end
   end

   assign status = '{paused: sus_q, write_enable_latch: wel_q, write_in_progress: wip_q};
   assign erase_block_pulse = ebp_q;
   assign erase_block_index = ebi_q;
   assign erase_all_pulse = eap_q;

   // Checks
   a_block_start: assert property (@(posedge mclk) disable iff (!rstn)
      (blk_cmd && wel_q && !wip_q && !sus_q && !rpend_q && block_protect_bits == '0)
      |=> wip_q && op_q == FES_OP_BLOCK) else $error("block erase did not start");
   a_block_wel_drop: assert property (@(posedge mclk) disable iff (!rstn)
      (wip_q && op_q == FES_OP_BLOCK) |=> !wel_q) else $error("latch kept in erase");
   a_protect_guard: assert property (@(posedge mclk) disable iff (!rstn)
      (!wip_q && !rpend_q && blk_cmd && block_protect_bits == 5'h1f) |=> !wip_q)
      else $error("protected block erased");
   a_chip_needs_wel: assert property (@(posedge mclk) disable iff (!rstn)
      (chip_cmd && !wel_q && !wip_q && !rpend_q && !sus_q) |=> !wip_q)
      else $error("chip erase without latch");
   a_chip_protect: assert property (@(posedge mclk) disable iff (!rstn)
      (chip_cmd && block_protect_bits != '0 && !wip_q && !rpend_q) |=> !wip_q)
      else $error("chip erase with protection");
   a_chip_end: assert property (@(posedge mclk) disable iff (!rstn)
      ($fell(wip_q) && $past(op_q) == FES_OP_CHIP) |-> !wel_q && erase_all_pulse)
      else $error("chip erase end wrong");
   a_chip_nosus: assert property (@(posedge mclk) disable iff (!rstn)
      (op_q == FES_OP_CHIP && wip_q) |=> !sus_q) else $error("suspend in chip erase");
   a_resume_timing: assert property (@(posedge mclk) disable iff (!rstn)
      ($fell(sus_q)) |-> ##[1:5] wip_q) else $error("busy late after resume");
   // A resume seen while nothing is paused must not start the busy countdown
   a_resume_guard: assert property (@(posedge mclk) disable iff (!rstn)
      (frame_end && frame_q.bits == BITS_OPCODE && frame_q.opcode == OP_RESUME
       && !sus_q && !rpend_q) |=> !rpend_q && !sus_q)
      else $error("resume without pause");
endmodule : fes_sequencer

//--- verif/fes_host_model.sv
/* Host link model: frames commands on chip select, serial clock and data.
   Assumes the bench calls send at a falling mclk edge. */
`timescale 1ns/1ps
module fes_host_model (
   output logic chip_select_n,
   output logic serial_clock,
   output logic serial_in_line
);
   initial begin
      chip_select_n = 1'b1;
      serial_clock = 1'b0;
      serial_in_line = 1'b0;
   end
   // Half period 160 ns; clock stands low between frames
   task automatic send(input logic [39:0] d, input int n);
      chip_select_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in_line = d[i];
         #160 serial_clock = 1'b1;
         #160 serial_clock = 1'b0;
      end
      #160 chip_select_n = 1'b1;
      serial_in_line = ~serial_in_line; // Released line shows no stale bit
      #320;
   endtask : send
endmodule : fes_host_model

//--- verif/testbench.sv
/* Self-checking bench for the erase, suspend and resume sequencer.
   Assumes the host model and shortened self-timed durations. */
`timescale 1ns/1ps
module testbench;
   import fes_pkg::*;
   localparam int DUR = 300;
   logic mclk, rstn, cs_n, sclk, sin, wen, go_se, go_pp, blk_p, all_p, mw;
   logic [BP_W-1:0] bp;
   fes_status_t status;
   logic [BLOCK_IDX_W-1:0] blk_idx;
   logic [ADDR_W-1:0] addr;
   int n_errors = 0, n_checks = 0, n_busy = 0, n_blk = 0, n_all = 0, seed = 14448;
   int mp = 0, mb = 0, mk = 0, eb = 0, ea = 0, b0;
   fes_host_model i_fes_host_model (.chip_select_n(cs_n), .serial_clock(sclk),
      .serial_in_line(sin));
   fes_sequencer #(.BLOCK_ERASE_CYC(DUR), .CHIP_ERASE_CYC(DUR + 100),
      .SECTOR_ERASE_CYC(DUR), .PAGE_PROG_CYC(DUR)) i_fes_sequencer (.mclk(mclk),
      .rstn(rstn), .chip_select_n(cs_n), .serial_clock(sclk), .serial_in_line(sin),
      .block_protect_bits(bp), .set_write_enable(wen), .start_sector_erase(go_se),
      .start_page_program(go_pp), .status(status), .erase_block_pulse(blk_p),
      .erase_block_index(blk_idx), .erase_all_pulse(all_p));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Busy cycles and completion pulses, sampled away from the launching edge
   always @(negedge mclk) begin
      n_busy += (status.write_in_progress === 1'b1);
      n_blk += (blk_p === 1'b1);
      n_all += (all_p === 1'b1);
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // Reference model: does the device take this frame
   function automatic bit accept(input logic [39:0] d, input int n);
      logic [7:0] op;
      op = d[n-1 -: 8];
      case (op)
         OP_BLOCK_ERASE64: return n == 32 && mw === 1'b1 && !mb && !(bp != 0 &&
            (bp > 8 || d[23:16] >= 256 - (1 << bp)));
         OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: return n == 8 && mw === 1'b1 && !mb && bp == 0;
         OP_SUSPEND: return n == 8 && mb && mk != 1;
         OP_RESUME: return n == 8 && mp && !mb;
         default: return 0;
      endcase
   endfunction : accept
   task automatic frame(input logic [39:0] d, input int n);
      logic [7:0] op;
      op = d[n-1 -: 8];
      if (accept(d, n)) begin
         mb = (op != OP_SUSPEND);
         mp = (op == OP_SUSPEND);
         if (op == OP_BLOCK_ERASE64 || op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B) begin
            mk = (op != OP_BLOCK_ERASE64);
            mw = mk[0];
         end
      end
      i_fes_host_model.send(d, n);
      repeat (12) @(negedge mclk);
      chk("paused and busy", {mp[0], mb[0]}, {status.paused, status.write_in_progress});
      if (mw !== 1'bx)
         chk("write latch", mw, status.write_enable_latch);
   endtask : frame
   task automatic wel_on();
      wen = 1'b1;
      @(negedge mclk);
      wen = 1'b0;
      @(negedge mclk);
      mw = 1'b1;
      chk("write latch set", 1, status.write_enable_latch);
   endtask : wel_on
   // Wait for the end of a self-timed cycle, then compare with the model
   task automatic done(input int dur);
      int t;
      t = 0;
      while (status.write_in_progress !== 1'b0 && t < 3000) begin
         @(negedge mclk);
         t++;
      end
      chk("busy span ok", 1, n_busy - b0 >= dur && n_busy - b0 <= dur + 6);
      mb = 0;
      mw = 1'b0;
      repeat (2) @(negedge mclk);
      chk("idle status", {mp[0], 2'b00}, status);
      chk("block pulses", eb, n_blk);
      chk("chip pulses", ea, n_all);
   endtask : done
   initial begin
      rstn = 1'b0;
      {wen, go_se, go_pp, mw} = 4'h0;
      bp = 5'h00;
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      chk("reset status", 0, status);
      addr = $random(seed);
      frame({OP_BLOCK_ERASE64, addr}, 32);
      frame(OP_CHIP_ERASE_A, 8);
      wel_on();
      frame({OP_BLOCK_ERASE64, addr, 1'b1}, 33);
      frame({OP_BLOCK_ERASE64, addr[23:1]}, 31);
      frame({OP_CHIP_ERASE_B, 1'b0}, 9);
      frame(OP_RESUME, 8);
      bp = 5'h01;
      frame({OP_BLOCK_ERASE64, 8'hff, addr[15:0]}, 32);
      frame(OP_CHIP_ERASE_A, 8);
      bp = 5'h1f;
      frame({OP_BLOCK_ERASE64, addr}, 32);
      bp = 5'h00;
      // Block, sector and program runs, each paused and resumed; no erase while paused
      for (int k = 0; k < 3; k++) begin
         wel_on();
         b0 = n_busy;
         addr = $random(seed);
         if (k == 0)
            frame({OP_BLOCK_ERASE64, addr}, 32);
         else begin
            go_se = (k == 1);
            go_pp = (k == 2);
            @(negedge mclk);
            {go_se, go_pp, mw} = 3'b00x;
            {mb, mk} = {32'd1, 32'd2};
         end
         frame(OP_SUSPEND, 8);
         repeat (400) @(negedge mclk);
         chk("block pulses paused", eb, n_blk);
         frame(OP_RESUME, 8);
         eb += (k == 0);
         done(DUR);
         if (k == 0)
            chk("block index", addr[23:16], blk_idx);
      end
      // Both chip erase codes; suspend and resume ignored while it runs
      for (int c = 0; c < 2; c++) begin
         wel_on();
         b0 = n_busy;
         ea++;
         frame(c ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A, 8);
         frame(OP_SUSPEND, 8);
         frame(OP_RESUME, 8);
         done(DUR + 100);
      end
      tally_and_finish();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #1_000_000;
      n_errors++;
      tally_and_finish();
   end
endmodule : testbench
